// *** rtl/dpb_dual_ram.sv ***
/*
  Dual-port block memory with per-port width, write policy, preset and
  startup words, configured over APB.
  Assumes ref_clk at 50 MHz; port pins are asynchronous and slow.
*/
`timescale 1ns/1ps
module dpb_dual_ram
  import dpb_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic port_clock_a,
  input wire logic port_activate_a,
  input wire logic store_strobe_a,
  input wire logic output_sync_preset_a,
  input wire logic [DPB_ADDR_W-1:0] location_select_a,
  input wire logic [DPB_DATA_W-1:0] write_word_a,
  input wire logic [DPB_XTRA_W-1:0] write_extra_bits_a,
  output logic [DPB_DATA_W-1:0] read_word_a,
  output logic [DPB_XTRA_W-1:0] read_extra_bits_a,
  input wire logic port_clock_b,
  input wire logic port_activate_b,
  input wire logic store_strobe_b,
  input wire logic output_sync_preset_b,
  input wire logic [DPB_ADDR_W-1:0] location_select_b,
  input wire logic [DPB_DATA_W-1:0] write_word_b,
  input wire logic [DPB_XTRA_W-1:0] write_extra_bits_b,
  output logic [DPB_DATA_W-1:0] read_word_b,
  output logic [DPB_XTRA_W-1:0] read_extra_bits_b
);

  // ==========================================================
  // Width decoding
  // Lane = 8 data bits plus their extra bit at bit 8
  function automatic logic [DPB_IDX_W-1:0] lane_index(
    input dpb_width_e m,
    input logic [DPB_ADDR_W-1:0] a
  );
    case (m)
      DPB_W1: lane_index = a[13:3];
      DPB_W2: lane_index = a[12:2];
      DPB_W4: lane_index = a[11:1];
      DPB_W9: lane_index = a[10:0];
      DPB_W18: lane_index = {a[9:0], 1'b0};
      default: lane_index = {a[8:0], 2'b00};
    endcase
  endfunction : lane_index

  function automatic logic [2:0] lane_count(input dpb_width_e m);
    case (m)
      DPB_W18: lane_count = 3'h2;
      DPB_W36: lane_count = 3'h4;
      default: lane_count = 3'h1;
    endcase
  endfunction : lane_count

  // Merge a written word into the lanes it touches
  function automatic logic [DPB_WORD_W-1:0] merge_word(
    input dpb_width_e m,
    input logic [DPB_ADDR_W-1:0] a,
    input logic [DPB_WORD_W-1:0] old,
    input logic [DPB_DATA_W-1:0] d,
    input logic [DPB_XTRA_W-1:0] x
  );
    logic [DPB_WORD_W-1:0] r;
    r = old;
    case (m)
      DPB_W1: r[a[2:0]] = d[0];
      DPB_W2: r[{a[1:0], 1'b0} +: 2] = d[1:0];
      DPB_W4: r[{a[0], 2'b00} +: 4] = d[3:0];
      DPB_W9: r[8:0] = {x[0], d[7:0]};
      DPB_W18: r[17:0] = {x[1], d[15:8], x[0], d[7:0]};
      default: r = {x[3], d[31:24], x[2], d[23:16], x[1], d[15:8], x[0], d[7:0]};
    endcase
    merge_word = r;
  endfunction : merge_word

  // Lanes to {extra, data} as the port shows them; unused bits read zero
  function automatic logic [DPB_WORD_W-1:0] view_word(
    input dpb_width_e m,
    input logic [DPB_ADDR_W-1:0] a,
    input logic [DPB_WORD_W-1:0] b
  );
    case (m)
      DPB_W1: view_word = {35'h0, b[a[2:0]]};
      DPB_W2: view_word = {34'h0, b[{a[1:0], 1'b0} +: 2]};
      DPB_W4: view_word = {32'h0, b[{a[0], 2'b00} +: 4]};
      DPB_W9: view_word = {3'h0, b[8], 24'h0, b[7:0]};
      DPB_W18: view_word = {2'h0, b[17], b[8], 16'h0, b[16:9], b[7:0]};
      default: view_word = {b[35], b[26], b[17], b[8], b[34:27], b[25:18], b[16:9], b[7:0]};
    endcase
  endfunction : view_word

  // ==========================================================
  // Configuration state
  logic [8:0] cfg_a;
  logic [8:0] cfg_b;
  logic [35:0] pre_a;
  logic [35:0] pre_b;
  logic [35:0] ini_a;
  logic [35:0] ini_b;
  logic reload;
  logic coll;
  logic [15:0] cnt_a;
  logic [15:0] cnt_b;
  logic [35:0] q_a;
  logic [35:0] q_b;

  // ==========================================================
  // Port front ends
  logic fire [2];
  logic en [2];
  logic we [2];
  logic pre [2];
  logic [DPB_ADDR_W-1:0] addr [2];
  logic [DPB_DATA_W-1:0] data [2];
  logic [DPB_XTRA_W-1:0] extra [2];
  logic [8:0] cfg [2];

  assign cfg[0] = cfg_a;
  assign cfg[1] = cfg_b;

  dpb_port_front u_front_a (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .pins({port_clock_a, port_activate_a, store_strobe_a, output_sync_preset_a,
           location_select_a, write_word_a, write_extra_bits_a}),
    .inv(cfg_a[DPB_CFG_INV_LSB +: 4]),
    .fire(fire[0]),
    .en(en[0]),
    .we(we[0]),
    .pre(pre[0]),
    .addr(addr[0]),
    .data(data[0]),
    .extra(extra[0])
  );

  dpb_port_front u_front_b (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .pins({port_clock_b, port_activate_b, store_strobe_b, output_sync_preset_b,
           location_select_b, write_word_b, write_extra_bits_b}),
    .inv(cfg_b[DPB_CFG_INV_LSB +: 4]),
    .fire(fire[1]),
    .en(en[1]),
    .we(we[1]),
    .pre(pre[1]),
    .addr(addr[1]),
    .data(data[1]),
    .extra(extra[1])
  );

  // ==========================================================
  // Storage access per port
  logic [8:0] mem [DPB_LANES];
  dpb_width_e wid [2];
  dpb_wmode_e wmode [2];
  logic [DPB_IDX_W-1:0] base [2];
  logic [2:0] lanes [2];
  logic [DPB_WORD_W-1:0] old_lanes [2];
  logic [DPB_WORD_W-1:0] new_lanes [2];
  logic [DPB_WORD_W-1:0] rd_old [2];
  logic [DPB_WORD_W-1:0] rd_new [2];
  logic act [2];
  logic wr [2];

  for (genvar p = 0; p < 2; p++) begin : g_port
    assign wid[p] = dpb_width_e'(cfg[p][DPB_CFG_WID_LSB +: 3]);
    assign wmode[p] = dpb_wmode_e'(cfg[p][DPB_CFG_MODE_LSB +: 2]);
    assign base[p] = lane_index(wid[p], addr[p]);
    assign lanes[p] = lane_count(wid[p]);
    assign old_lanes[p] = {mem[DPB_IDX_W'(base[p] + 11'h3)], mem[DPB_IDX_W'(base[p] + 11'h2)],
                           mem[DPB_IDX_W'(base[p] + 11'h1)], mem[base[p]]};
    assign new_lanes[p] = merge_word(wid[p], addr[p], old_lanes[p], data[p], extra[p]);
    assign rd_old[p] = view_word(wid[p], addr[p], old_lanes[p]);
    assign rd_new[p] = view_word(wid[p], addr[p], new_lanes[p]);
    assign act[p] = fire[p] & en[p];
    assign wr[p] = act[p] & we[p];
  end

  // Port B is applied last, so it wins a same-lane clash
  always_ff @(posedge ref_clk) begin
    for (int p = 0; p < 2; p++) begin
      for (int k = 0; k < 4; k++) begin
        if (wr[p] && (k < 32'(lanes[p]))) begin
          mem[DPB_IDX_W'(base[p] + DPB_IDX_W'(k))] <= new_lanes[p][k*9 +: 9];
        end
      end
    end
  end

  // ==========================================================
  // Output latches
  dpb_out_latch u_out_a (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .fire(fire[0]),
    .en(en[0]),
    .we(we[0]),
    .pre(pre[0]),
    .reload(reload),
    .wmode(wmode[0]),
    .preset_word(pre_a),
    .init_word(ini_a),
    .rd_old(rd_old[0]),
    .rd_new(rd_new[0]),
    .q(q_a)
  );

  dpb_out_latch u_out_b (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .fire(fire[1]),
    .en(en[1]),
    .we(we[1]),
    .pre(pre[1]),
    .reload(reload),
    .wmode(wmode[1]),
    .preset_word(pre_b),
    .init_word(ini_b),
    .rd_old(rd_old[1]),
    .rd_new(rd_new[1]),
    .q(q_b)
  );

  assign read_word_a = q_a[31:0];
  assign read_extra_bits_a = q_a[35:32];
  assign read_word_b = q_b[31:0];
  assign read_extra_bits_b = q_b[35:32];

  // ==========================================================
  // Conflict watch and write counters
  wire coll_evt = act[0] & act[1] & (wr[0] | wr[1]) & (base[0] == base[1]);

  // ==========================================================
  // APB slave
  wire setup = psel & ~penable;
  wire wr_acc = psel & penable & pready & pwrite;
  wire w_cfg_a = wr_acc & (paddr == DPB_OFF_CFG_A);
  wire w_cfg_b = wr_acc & (paddr == DPB_OFF_CFG_B);
  wire w_pre_a = wr_acc & (paddr == DPB_OFF_PRE_A);
  wire w_prex_a = wr_acc & (paddr == DPB_OFF_PREX_A);
  wire w_pre_b = wr_acc & (paddr == DPB_OFF_PRE_B);
  wire w_prex_b = wr_acc & (paddr == DPB_OFF_PREX_B);
  wire w_ini_a = wr_acc & (paddr == DPB_OFF_INI_A);
  wire w_inix_a = wr_acc & (paddr == DPB_OFF_INIX_A);
  wire w_ini_b = wr_acc & (paddr == DPB_OFF_INI_B);
  wire w_inix_b = wr_acc & (paddr == DPB_OFF_INIX_B);
  wire w_cmd = wr_acc & (paddr == DPB_OFF_CMD);
  wire w_stat = wr_acc & (paddr == DPB_OFF_STAT);
  wire clr_coll = w_stat & pwdata[DPB_STAT_COLL];

  logic [31:0] rd_val;
  logic hit;

  always_comb begin
    hit = 1'b1;
    rd_val = 32'h0000_0000;
    if (paddr == DPB_OFF_CFG_A) begin
      rd_val = {23'h0, cfg_a};
    end else if (paddr == DPB_OFF_CFG_B) begin
      rd_val = {23'h0, cfg_b};
    end else if (paddr == DPB_OFF_PRE_A) begin
      rd_val = pre_a[31:0];
    end else if (paddr == DPB_OFF_PREX_A) begin
      rd_val = {28'h0, pre_a[35:32]};
    end else if (paddr == DPB_OFF_PRE_B) begin
      rd_val = pre_b[31:0];
    end else if (paddr == DPB_OFF_PREX_B) begin
      rd_val = {28'h0, pre_b[35:32]};
    end else if (paddr == DPB_OFF_INI_A) begin
      rd_val = ini_a[31:0];
    end else if (paddr == DPB_OFF_INIX_A) begin
      rd_val = {28'h0, ini_a[35:32]};
    end else if (paddr == DPB_OFF_INI_B) begin
      rd_val = ini_b[31:0];
    end else if (paddr == DPB_OFF_INIX_B) begin
      rd_val = {28'h0, ini_b[35:32]};
    end else if (paddr == DPB_OFF_CMD) begin
      rd_val = 32'h0000_0000;
    end else if (paddr == DPB_OFF_OUT_A) begin
      rd_val = q_a[31:0];
    end else if (paddr == DPB_OFF_OUT_B) begin
      rd_val = q_b[31:0];
    end else if (paddr == DPB_OFF_STAT) begin
      rd_val = {31'h0, coll};
    end else if (paddr == DPB_OFF_CNT) begin
      rd_val = {cnt_b, cnt_a};
    end else begin
      hit = 1'b0;
    end
  end

  // Answer is ready in the first access cycle
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup;
      pslverr <= setup & ~hit;
      if (setup && !pwrite) begin
        prdata <= rd_val;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cfg_a <= DPB_CFG_RST;
      cfg_b <= DPB_CFG_RST;
    end else begin
      if (w_cfg_a) begin
        cfg_a <= pwdata[8:0];
      end
      if (w_cfg_b) begin
        cfg_b <= pwdata[8:0];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pre_a <= DPB_PRE_RST;
      pre_b <= DPB_PRE_RST;
    end else begin
      if (w_pre_a) pre_a[31:0] <= pwdata;
      if (w_prex_a) pre_a[35:32] <= pwdata[3:0];
      if (w_pre_b) pre_b[31:0] <= pwdata;
      if (w_prex_b) pre_b[35:32] <= pwdata[3:0];
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ini_a <= DPB_INIT_RST;
      ini_b <= DPB_INIT_RST;
    end else begin
      if (w_ini_a) ini_a[31:0] <= pwdata;
      if (w_inix_a) ini_a[35:32] <= pwdata[3:0];
      if (w_ini_b) ini_b[31:0] <= pwdata;
      if (w_inix_b) ini_b[35:32] <= pwdata[3:0];
    end
  end

  // Reload pulse acts as a global output reset; storage is left alone
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      reload <= 1'b0;
    end else begin
      reload <= w_cmd & pwdata[DPB_CMD_RELOAD];
    end
  end

  // Sticky conflict flag: a new event beats a clear in the same cycle
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      coll <= 1'b0;
    end else begin
      coll <= coll_evt | (coll & ~clr_coll);
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_a <= 16'h0000;
      cnt_b <= 16'h0000;
    end else begin
      if (wr[0]) cnt_a <= 16'(cnt_a + 16'h0001);
      if (wr[1]) cnt_b <= 16'(cnt_b + 16'h0001);
    end
  end

endmodule : dpb_dual_ram

// *** rtl/dpb_out_latch.sv ***
/*
  Output latch of one port: preset, read, write-mode policy, startup word.
  Assumes all inputs are in the ref_clk domain.
*/
`timescale 1ns/1ps
module dpb_out_latch
  import dpb_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic fire,
  input wire logic en,
  input wire logic we,
  input wire logic pre,
  input wire logic reload,
  input wire dpb_wmode_e wmode,
  input wire logic [DPB_WORD_W-1:0] preset_word,
  input wire logic [DPB_WORD_W-1:0] init_word,
  input wire logic [DPB_WORD_W-1:0] rd_old,
  input wire logic [DPB_WORD_W-1:0] rd_new,
  output logic [DPB_WORD_W-1:0] q
);

  logic [DPB_WORD_W-1:0] wr_view;

  // ==========================================================
  // Output seen during a write
  always_comb begin
    case (wmode)
      DPB_NEW_FIRST: wr_view = rd_new;
      DPB_OLD_FIRST: wr_view = rd_old;
      default: wr_view = q;
    endcase
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      q <= DPB_INIT_RST;
    end else if (reload) begin
      q <= init_word;
    end else if (fire && en) begin
      if (pre) begin
        q <= preset_word;
      end else if (!we) begin
        q <= rd_old;
      end else begin
        q <= wr_view;
      end
    end
  end

endmodule : dpb_out_latch

// *** rtl/dpb_pkg.sv ***
/*
  Constants, types and register map of the dual-port block memory.
  Assumes one system clock; port clocks arrive as plain pins.
*/
// What this block does
// - Clock, enable, store strobe and preset are active high by default.
// - Each of those four controls per port has its own polarity inversion bit.
// - Active edge with enable and store strobe writes word and extra bits.
// - One total width per port sets data, extra and location select widths.
// - Extra bits are plain storage; no parity is generated or checked.
// - Active edge with enable, no store strobe, loads read outputs from memory.
// - New-first mode shows the freshly written word on the read output.
// - Old-first mode shows previous contents while the location updates.
// - Hold mode keeps the read output unchanged during writes.
// - Enable low means no read, no write, outputs and memory unchanged.
// - Preset on an active edge loads the preset word; never asynchronous.
// - Each port samples on its own clock; ports may be unrelated.
// - Widths 1,2,4,9,18,36 use 14,13,12,11,10,9 select lines.
// - Different port widths share storage; extra bits follow their bytes.
// - Widths 4, 2 and 1 carry no extra bits.
// - Startup loads each output latch with its startup word; memory untouched.
package dpb_pkg;

  typedef enum logic [2:0] {
    DPB_W1 = 3'h0,
    DPB_W2 = 3'h1,
    DPB_W4 = 3'h2,
    DPB_W9 = 3'h3,
    DPB_W18 = 3'h4,
    DPB_W36 = 3'h5
  } dpb_width_e;

  typedef enum logic [1:0] {
    DPB_NEW_FIRST = 2'h0,
    DPB_OLD_FIRST = 2'h1,
    DPB_HOLD = 2'h2
  } dpb_wmode_e;

  // ==========================================================
  // Geometry
  localparam int DPB_ADDR_W = 14;
  localparam int DPB_DATA_W = 32;
  localparam int DPB_XTRA_W = 4;
  localparam int DPB_WORD_W = 36;
  localparam int DPB_IDX_W = 11;
  localparam int DPB_LANES = 2048;
  localparam int DPB_BUS_W = 54;

  // ==========================================================
  // Register map
  localparam logic [7:0] DPB_OFF_CFG_A = 8'h00;
  localparam logic [7:0] DPB_OFF_CFG_B = 8'h04;
  localparam logic [7:0] DPB_OFF_PRE_A = 8'h08;
  localparam logic [7:0] DPB_OFF_PREX_A = 8'h0C;
  localparam logic [7:0] DPB_OFF_PRE_B = 8'h10;
  localparam logic [7:0] DPB_OFF_PREX_B = 8'h14;
  localparam logic [7:0] DPB_OFF_INI_A = 8'h18;
  localparam logic [7:0] DPB_OFF_INIX_A = 8'h1C;
  localparam logic [7:0] DPB_OFF_INI_B = 8'h20;
  localparam logic [7:0] DPB_OFF_INIX_B = 8'h24;
  localparam logic [7:0] DPB_OFF_CMD = 8'h28;
  localparam logic [7:0] DPB_OFF_OUT_A = 8'h2C;
  localparam logic [7:0] DPB_OFF_OUT_B = 8'h30;
  localparam logic [7:0] DPB_OFF_STAT = 8'h34;
  localparam logic [7:0] DPB_OFF_CNT = 8'h38;

  // ==========================================================
  // Fields and reset values
  localparam int DPB_CFG_WID_LSB = 0;
  localparam int DPB_CFG_MODE_LSB = 3;
  localparam int DPB_CFG_INV_LSB = 5;
  localparam int DPB_INV_CLK = 0;
  localparam int DPB_INV_EN = 1;
  localparam int DPB_INV_WE = 2;
  localparam int DPB_INV_PRE = 3;
  localparam int DPB_CMD_RELOAD = 0;
  localparam int DPB_STAT_COLL = 0;
  localparam logic [8:0] DPB_CFG_RST = 9'h005;
  localparam logic [35:0] DPB_INIT_RST = 36'h0_0000_0000;
  localparam logic [35:0] DPB_PRE_RST = 36'h0_0000_0000;

endpackage : dpb_pkg

// *** rtl/dpb_port_front.sv ***
/*
  Port front end: brings one port's pins into the system clock domain,
  applies polarity and finds the active port clock edge.
  Assumes the port clock runs well below a quarter of ref_clk.
*/
`timescale 1ns/1ps
module dpb_port_front
  import dpb_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [DPB_BUS_W-1:0] pins,
  input wire logic [3:0] inv,
  output logic fire,
  output logic en,
  output logic we,
  output logic pre,
  output logic [DPB_ADDR_W-1:0] addr,
  output logic [DPB_DATA_W-1:0] data,
  output logic [DPB_XTRA_W-1:0] extra
);

  logic [DPB_BUS_W-1:0] s1;
  logic [DPB_BUS_W-1:0] s2;
  logic [DPB_BUS_W-1:0] s3;

  // ==========================================================
  // Two-stage synchroniser plus history stage
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end else begin
      s1 <= pins;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // Pins: {clk, en, we, pre, addr, data, extra}; values taken before the edge
  assign fire = inv[DPB_INV_CLK] ? (s3[53] & ~s2[53]) : (s2[53] & ~s3[53]);
  assign en = s3[52] ^ inv[DPB_INV_EN];
  assign we = s3[51] ^ inv[DPB_INV_WE];
  assign pre = s3[50] ^ inv[DPB_INV_PRE];
  assign addr = s3[49:36];
  assign data = s3[35:4];
  assign extra = s3[3:0];

endmodule : dpb_port_front

// *** testbench/dpb_dual_ram_props.sv ***
/*
  Checker for the dual-port memory top: APB handshake and read latch timing.
  Assumes port A keeps default polarity; one ref_clk domain.
*/
`timescale 1ns/1ps
module dpb_dual_ram_props
  import dpb_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic port_clock_a,
  input wire logic port_activate_a,
  input wire logic [DPB_DATA_W-1:0] read_word_a,
  input wire logic port_clock_b,
  input wire logic [DPB_DATA_W-1:0] read_word_b
);
  logic [3:0] age_a, age_b, age_w;
  logic ck_a, ck_b;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  // ==========================================================
  // Cycles since a port pin edge or an APB write
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      {age_a, age_b, age_w, ck_a, ck_b} <= 14'h3FFC;
    end else begin
      {ck_a, ck_b} <= {port_clock_a, port_clock_b};
      age_a <= (ck_a != port_clock_a) ? 4'h0 : age_a + 4'(age_a != 4'hF);
      age_b <= (ck_b != port_clock_b) ? 4'h0 : age_b + 4'(age_b != 4'hF);
      age_w <= (psel && penable && pready && pwrite) ? 4'h0 : age_w + 4'(age_w != 4'hF);
    end
  end
  // ==========================================================
  // Properties
  pready_once_a: assert property (pready |=> !pready) else $error("pready held too long");
  pready_timely_a: assert property (psel && !penable |=> pready) else $error("pready late");
  pready_placed_a: assert property (pready |-> psel && penable) else $error("pready outside access");
  slverr_paired_a: assert property (pslverr |-> pready) else $error("pslverr without pready");
  prdata_hold_a: assert property ($changed(prdata) |-> $past(psel && !penable && !pwrite))
    else $error("prdata moved outside read setup");
  rda_gated_a: assert property ($changed(read_word_a) |-> $past(port_activate_a, 4) || age_w <= 4'h3)
    else $error("port a output moved while disabled");
  rda_cause_a: assert property ($changed(read_word_a) |-> age_a <= 4'h5 || age_w <= 4'h3)
    else $error("port a output moved without its clock");
  rdb_cause_a: assert property ($changed(read_word_b) |-> age_b <= 4'h5 || age_w <= 4'h3)
    else $error("port b output moved without its clock");
  rda_latency_a: assert property ($rose(port_clock_a) |=> $stable(read_word_a) [*2])
    else $error("port a output too early");
endmodule : dpb_dual_ram_props

// *** testbench/dpb_dual_ram_test.sv ***
/*
  Self-checking bench of the dual-port memory, APB master and two port users.
  Assumes the ports are used one at a time, never at once on the same location.
*/
`timescale 1ns/1ps
`define CHK(n, x, s) begin comparisons++; if ((x) !== (s)) begin fails++; $display("mismatch %0s expected %h seen %h", n, x, s); end end
module dpb_dual_ram_test
  import dpb_pkg::*;
;
  logic ref_clk, nrst, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, wd_a, wd_b, rd_a, rd_b;
  logic clk_a, en_a, we_a, pre_a, done_a, clk_b, en_b, we_b, pre_b, done_b;
  logic [13:0] addr_a, addr_b;
  logic [3:0] wx_a, wx_b, rx_a, rx_b, inv_b;
  logic [35:0] qa[$], qb[$], ea, eb;
  int fails, comparisons, seed;
  dpb_dual_ram u_dpb_dual_ram (.ref_clk(ref_clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .port_clock_a(clk_a), .port_activate_a(en_a), .store_strobe_a(we_a), .output_sync_preset_a(pre_a),
    .location_select_a(addr_a), .write_word_a(wd_a), .write_extra_bits_a(wx_a), .read_word_a(rd_a),
    .read_extra_bits_a(rx_a), .port_clock_b(clk_b), .port_activate_b(en_b), .store_strobe_b(we_b),
    .output_sync_preset_b(pre_b), .location_select_b(addr_b), .write_word_b(wd_b),
    .write_extra_bits_b(wx_b), .read_word_b(rd_b), .read_extra_bits_b(rx_b));
  dpb_port_user u_user_a (.ref_clk(ref_clk), .inv(4'h0), .clk(clk_a), .en(en_a), .we(we_a), .pre(pre_a),
    .addr(addr_a), .wd(wd_a), .wx(wx_a), .done(done_a));
  dpb_port_user u_user_b (.ref_clk(ref_clk), .inv(inv_b), .clk(clk_b), .en(en_b), .we(we_b), .pre(pre_b),
    .addr(addr_b), .wd(wd_b), .wx(wx_b), .done(done_b));
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  // ==========================================================
  // Tasks
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
    output logic e);
    @(posedge ref_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    {psel, penable} <= 2'h0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask : wr
  task automatic po(input logic b, input logic e, input logic w, input logic p, input logic [13:0] a,
    input logic [35:0] d, input logic [35:0] x);
    if (b) begin
      qb.push_back(x);
      u_user_b.op(e, w, p, a, d);
    end else begin
      qa.push_back(x);
      u_user_a.op(e, w, p, a, d);
    end
  endtask : po
  function automatic logic [35:0] rnd();
    return 36'({$random(seed), $random(seed)});
  endfunction : rnd
  task tally_and_finish;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : tally_and_finish
  // ==========================================================
  // Result watcher
  always @(posedge ref_clk) begin
    if (done_a === 1'b1) begin
      ea = qa.pop_front();
      `CHK("port_a", ea, {rx_a, rd_a})
    end
    if (done_b === 1'b1) begin
      eb = qb.pop_front();
      `CHK("port_b", eb, {rx_b, rd_b})
    end
  end
  // Ops take 11 cycles each; far above the whole run
  initial begin
    #(20 * 10000);
    fails++;
    tally_and_finish();
  end
  // ==========================================================
  // Main sequence
  initial begin
    logic [31:0] r;
    logic e;
    logic [35:0] d1, d2, d3, d5, ex;
    logic [13:0] a1;
    int u, n, i;
    seed = 71456;
    {nrst, psel, penable, pwrite, paddr, pwdata} = 44'h0;
    inv_b = 4'h0;
    repeat (6) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    `CHK("startup", 72'h0, {rx_a, rd_a, rx_b, rd_b})
    for (int k = 0; k < 16; k++) begin
      apb(1'b0, 8'(k * 4), 32'h0, r, e);
      `CHK("reg", (k < 2) ? 32'h5 : 32'h0, r)
      `CHK("err", k == 15, e)
    end
    $display("test reset done");
    a1 = 14'($random(seed)) & 14'h01FF;
    d1 = rnd();
    po(0, 1, 1, 0, a1, d1, d1);
    po(1, 1, 0, 0, a1, 36'h0, d1);
    po(0, 1, 0, 0, a1, 36'h0, d1);
    wr(DPB_OFF_CFG_A, 32'h00D);
    d2 = rnd();
    po(0, 1, 1, 0, a1, d2, d1);
    po(0, 1, 0, 0, a1, 36'h0, d2);
    wr(DPB_OFF_CFG_A, 32'h015);
    d3 = rnd();
    po(0, 1, 1, 0, a1, d3, d2);
    po(0, 1, 0, 0, a1, 36'h0, d3);
    po(0, 0, 1, 0, a1, rnd(), d3);
    po(0, 1, 0, 0, a1, 36'h0, d3);
    $display("test write modes done");
    wr(DPB_OFF_PRE_A, 32'h1234_5678);
    wr(DPB_OFF_PREX_A, 32'h9);
    po(0, 1, 0, 1, a1, 36'h0, 36'h9_1234_5678);
    d5 = rnd();
    po(0, 1, 1, 1, a1, d5, 36'h9_1234_5678);
    po(0, 1, 0, 0, a1, 36'h0, d5);
    po(0, 0, 0, 1, a1, 36'h0, d5);
    wr(DPB_OFF_INI_A, 32'hCAFE_0001);
    wr(DPB_OFF_INIX_A, 32'h3);
    wr(DPB_OFF_CMD, 32'h1);
    repeat (4) @(posedge ref_clk);
    `CHK("reload", 72'h3_CAFE_0001_0_0000_0000, {rx_a, rd_a, rx_b, rd_b})
    po(0, 1, 0, 0, a1, 36'h0, d5);
    $display("test preset done");
    // Park the B clock high before its polarity flips
    inv_b <= 4'h1;
    po(1, 0, 0, 0, a1, 36'h0, 36'h0);
    wr(DPB_OFF_CFG_B, 32'h1E4);
    inv_b <= 4'hF;
    for (int k = 0; k < 5; k++) begin
      u = 1 << (4 - k);
      n = 32 / u;
      wr(DPB_OFF_CFG_B, 32'h1E0 + 32'(4 - k));
      for (int j = 0; j < 2; j++) begin
        i = j * (n - 1);
        ex = 36'h0;
        for (int b = 0; b < u; b++)
          ex[b] = d5[i * u + b];
        if (u == 8)
          ex[32] = d5[32 + i];
        if (u == 16)
          ex[33:32] = d5[32 + 2 * i +: 2];
        po(1, 1, 0, 0, 14'(a1 * n + i), 36'h0, ex);
      end
    end
    wr(DPB_OFF_CFG_B, 32'h1E3);
    po(1, 1, 1, 0, 14'(a1 * 4 + 2), 36'h1_0000_00A5, 36'h1_0000_00A5);
    ex = d5;
    ex[23:16] = 8'hA5;
    ex[34] = 1'b1;
    po(0, 1, 0, 0, a1, 36'h0, ex);
    apb(1'b0, DPB_OFF_CNT, 32'h0, r, e);
    `CHK("count", 32'h0001_0004, r)
    $display("test widths done");
    repeat (3) @(posedge ref_clk);
    tally_and_finish();
  end
endmodule : dpb_dual_ram_test
bind dpb_dual_ram dpb_dual_ram_props u_dpb_dual_ram_props (.ref_clk(ref_clk), .nrst(nrst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .port_clock_a(port_clock_a), .port_activate_a(port_activate_a), .read_word_a(read_word_a),
  .port_clock_b(port_clock_b), .read_word_b(read_word_b));

// *** testbench/dpb_port_user.sv ***
/*
  User logic model driving one memory port: one operation per call.
  Assumes ref_clk is the bench clock; inv gives pin polarity per control.
*/
`timescale 1ns/1ps
module dpb_port_user
  import dpb_pkg::*;
(
  input wire logic ref_clk,
  input wire logic [3:0] inv,
  output logic clk,
  output logic en,
  output logic we,
  output logic pre,
  output logic [DPB_ADDR_W-1:0] addr,
  output logic [DPB_DATA_W-1:0] wd,
  output logic [DPB_XTRA_W-1:0] wx,
  output logic done
);
  initial begin
    {clk, en, we, pre, done, addr, wd, wx} = 55'h0;
  end
  // ==========================================================
  // Pins set, one clock pulse, then pins released
  task automatic op(input logic e, input logic w, input logic p, input logic [13:0] a,
    input logic [35:0] d);
    @(posedge ref_clk);
    clk <= inv[0];
    en <= e ^ inv[1];
    we <= w ^ inv[2];
    pre <= p ^ inv[3];
    addr <= a;
    {wx, wd} <= d;
    repeat (3) @(posedge ref_clk);
    clk <= ~inv[0];
    repeat (3) @(posedge ref_clk);
    clk <= inv[0];
    repeat (3) @(posedge ref_clk);
    // Released controls go inactive; address and data lines show inverted values
    {pre, we, en} <= inv[3:1];
    addr <= ~a;
    {wx, wd} <= ~d;
    done <= 1'b1;
    @(posedge ref_clk);
    done <= 1'b0;
  endtask : op
endmodule : dpb_port_user
